// ### include/adc_dma_regs.svh
// Register map, field positions, reset values for the ADC result transfer engine
`ifndef ADC_DMA_REGS_SVH
`define ADC_DMA_REGS_SVH

`define OFS_IRQ_PENDING     32'h4000A810
`define OFS_IRQ_ENABLE      32'h4000A850
`define OFS_XFER_CONTROL    32'h4000D010
`define OFS_XFER_STATUS     32'h4000D014
`define OFS_BUF_START       32'h4000D018
`define OFS_BUF_LENGTH      32'h4000D01C
`define OFS_NEXT_WRITE      32'h4000D020
`define OFS_STORED_COUNT    32'h4000D024

`define RST_BUF_START       14'h0000
`define RST_BUF_LENGTH      13'h0000
`define RST_IRQ_ENABLE      5'h00
`define RST_IRQ_PENDING     5'h00
`define RAM_BASE_ADDR       32'h20000000

`define BIT_OVERFLOW_IRQ    4
`define BIT_SATURATION_IRQ  3
`define BIT_BUFFER_FULL_IRQ 2
`define BIT_BUFFER_HALF_IRQ 1
`define BIT_RESULT_READY    0

`define BIT_TRANSFER_LOAD   0
`define BIT_WRAP_MODE       1
`define BIT_ENGINE_RESET    4
`define BIT_ENGINE_ACTIVE   0
`define BIT_OVERFLOW_STATUS 1

`define ADDR_STEP           14'h0002
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// ### include/adc_dma_pkg.sv
// Types shared by the ADC result transfer engine
package adc_dma_pkg;

    typedef enum logic [2:0] {
        ENG_IDLE = 3'h1,
        ENG_LOAD = 3'h2,
        ENG_RUN  = 3'h4
    } eng_state_t;

endpackage

// ### src/adc_result_dma.sv
// ADC result transfer engine with second-level interrupt flags and AXI4-Lite registers
//
// Notes on behaviour
// R1: Buffer start address bit 0 always reads zero, whatever software writes.
// R2: Buffer length counts 16-bit results; buffer spans twice that in bytes.
// R3: Read-only next-write address shows the halfword target of the next store.
// R4: Read-only stored count shows results written since load, engine reset or the last wrap.
// R5: After reset start and next-write read 0x20000000; length and count zero.
// R6: Overflow sets pending bit 4.
// R7: Gain saturation sets pending bit 3.
// R8: Buffer becoming full sets pending bit 2.
// R9: Buffer becoming half full sets pending bit 1.
// R10: A new conversion result sets pending bit 0.
// R11: Enable register holds one gate per flag at bits 4 down to 0.
// R12: Enabled flags combine into one peripheral interrupt request.
// R13: Software uses the top-level request only to mask the whole block.
// R14: Writing one to load starts transfer; bit clears when started or reset.
// R15: Linear mode stops when full; wrap mode restarts at start address.
// R16: Engine reset bit resets engine, clears overflow status, self-clears.
// R17: Overflow arises when a result arrives while the engine is inactive.
// R18: Half flag at count equal half length; full flag at count equal length.
// R19: Flags stay set until software clears; request is OR of enabled flags.
// R20: Each store writes halfword at current address, then adds two and counts one, or at a wrap reloads start and zeroes count.
`timescale 1ns/100ps
`include "adc_dma_regs.svh"

module adc_result_dma (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    // AXI4-Lite write address and data
    input  wire logic [31:0] AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    // AXI4-Lite write response
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    // AXI4-Lite read
    input  wire logic [31:0] ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY,
    // Conversion core
    input  wire logic        ADC_RESULT_VALID,
    input  wire logic [15:0] ADC_RESULT,
    input  wire logic        ADC_GAIN_SAT,
    // RAM write port
    output logic             RAM_WR_EN,
    output logic [31:0]      RAM_WR_ADDR,
    output logic [15:0]      RAM_WR_DATA,
    // Peripheral interrupt request
    output logic             IRQ_ADC
);

    logic [31:0]               aw_addr_ff;
    logic                      aw_held_ff;
    logic [31:0]               w_data_ff;
    logic [3:0]                w_strb_ff;
    logic                      w_held_ff;
    logic                      bvalid_ff;
    logic [1:0]                bresp_ff;
    logic                      rvalid_ff;
    logic [1:0]                rresp_ff;
    logic [31:0]               rdata_ff;
    logic                      do_write;
    logic                      wr_hit;
    logic [31:0]               rd_data;
    logic                      rd_hit;

    logic [13:0]               start_ff;
    logic [12:0]               length_ff;
    logic [13:0]               cur_ff;
    logic [12:0]               count_ff;
    logic                      wrap_ff;
    logic                      ovf_status_ff;
    logic [4:0]                enable_ff;
    logic [4:0]                pending_ff;
    logic [4:0]                nxt_pending;
    logic [4:0]                irq_set;
    logic [4:0]                irq_clr;
    adc_dma_pkg::eng_state_t   state_ff;

    logic [31:0]               wr_word;
    logic [31:0]               start_word;
    logic [31:0]               length_word;
    logic                      wr_ctrl;
    logic                      load_req;
    logic                      eng_rst_req;
    logic                      store;
    logic [12:0]               nxt_count;
    logic                      hit_full;
    logic                      hit_half;
    logic                      overflow_ev;
    logic                      ram_we_ff;
    logic [31:0]               ram_addr_ff;
    logic [15:0]               ram_data_ff;
    logic                      irq_ff;

    // Byte-lane merge of a write into an existing register value
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Bus: address and data are taken in either order, response after both
    assign AWREADY  = !aw_held_ff && !bvalid_ff;
    assign WREADY   = !w_held_ff && !bvalid_ff;
    assign BVALID   = bvalid_ff;
    assign BRESP    = bresp_ff;
    assign ARREADY  = !rvalid_ff;
    assign RVALID   = rvalid_ff;
    assign RDATA    = rdata_ff;
    assign RRESP    = rresp_ff;
    assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            aw_held_ff <= 1'b0;
            aw_addr_ff <= 32'h00000000;
        end else if (AWVALID && AWREADY) begin
            aw_held_ff <= 1'b1;
            aw_addr_ff <= AWADDR;
        end else if (do_write) begin
            aw_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            w_held_ff <= 1'b0;
            w_data_ff <= 32'h00000000;
            w_strb_ff <= 4'h0;
        end else if (WVALID && WREADY) begin
            w_held_ff <= 1'b1;
            w_data_ff <= WDATA;
            w_strb_ff <= WSTRB;
        end else if (do_write) begin
            w_held_ff <= 1'b0;
        end
    end

    always_comb begin
        unique case (aw_addr_ff)
            `OFS_IRQ_PENDING, `OFS_IRQ_ENABLE, `OFS_XFER_CONTROL, `OFS_XFER_STATUS,
            `OFS_BUF_START, `OFS_BUF_LENGTH, `OFS_NEXT_WRITE, `OFS_STORED_COUNT:
                wr_hit = 1'b1;
            default:
                wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= `RESP_OKAY;
        end else if (do_write) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (BREADY) begin
            bvalid_ff <= 1'b0;
        end
    end

    always_comb begin
        rd_hit  = 1'b1;
        rd_data = 32'h00000000;
        unique case (ARADDR)
            `OFS_IRQ_PENDING:  rd_data[4:0] = pending_ff;
            `OFS_IRQ_ENABLE:   rd_data[4:0] = enable_ff;
            `OFS_XFER_CONTROL: begin
                rd_data[`BIT_TRANSFER_LOAD] = (state_ff == adc_dma_pkg::ENG_LOAD); // R14
                rd_data[`BIT_WRAP_MODE]     = wrap_ff;
            end
            `OFS_XFER_STATUS: begin
                rd_data[`BIT_ENGINE_ACTIVE]   = (state_ff == adc_dma_pkg::ENG_RUN);
                rd_data[`BIT_OVERFLOW_STATUS] = ovf_status_ff;
            end
            `OFS_BUF_START:    rd_data = `RAM_BASE_ADDR | {18'h00000, start_ff}; // R5
            `OFS_BUF_LENGTH:   rd_data[12:0] = length_ff;
            `OFS_NEXT_WRITE:   rd_data = `RAM_BASE_ADDR | {18'h00000, cur_ff}; // R3
            `OFS_STORED_COUNT: rd_data[12:0] = count_ff; // R4
            default:           rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h00000000;
            rresp_ff  <= `RESP_OKAY;
        end else if (ARVALID && ARREADY) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_data;
            rresp_ff  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (RREADY) begin
            rvalid_ff <= 1'b0;
        end
    end

    // Register writes
    assign wr_word     = merge(32'h00000000, w_data_ff, w_strb_ff);
    assign wr_ctrl     = do_write && (aw_addr_ff == `OFS_XFER_CONTROL);
    assign load_req    = wr_ctrl && wr_word[`BIT_TRANSFER_LOAD]; // R14
    assign eng_rst_req = wr_ctrl && wr_word[`BIT_ENGINE_RESET]; // R16
    assign start_word  = merge({18'h00000, start_ff}, w_data_ff, w_strb_ff);
    assign length_word = merge({19'h00000, length_ff}, w_data_ff, w_strb_ff);

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            start_ff <= `RST_BUF_START; // R5
        end else if (do_write && aw_addr_ff == `OFS_BUF_START) begin
            start_ff <= {start_word[13:1], 1'b0}; // R1
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            length_ff <= `RST_BUF_LENGTH; // R5
        end else if (do_write && aw_addr_ff == `OFS_BUF_LENGTH) begin
            length_ff <= length_word[12:0]; // R2
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            wrap_ff <= 1'b0;
        end else if (wr_ctrl && w_strb_ff[0]) begin
            wrap_ff <= w_data_ff[`BIT_WRAP_MODE];
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            enable_ff <= `RST_IRQ_ENABLE;
        end else if (do_write && aw_addr_ff == `OFS_IRQ_ENABLE && w_strb_ff[0]) begin
            enable_ff <= w_data_ff[4:0]; // R11
        end
    end

    // Transfer engine
    assign store       = (state_ff == adc_dma_pkg::ENG_RUN) && ADC_RESULT_VALID && !eng_rst_req;
    assign nxt_count   = count_ff + 13'h0001; // R20
    assign hit_full    = store && (nxt_count == length_ff); // R18
    assign hit_half    = store && (length_ff[12:1] != 12'h000)
                         && (nxt_count == {1'b0, length_ff[12:1]}); // R18
    assign overflow_ev = ADC_RESULT_VALID && (state_ff != adc_dma_pkg::ENG_RUN); // R17

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_ff <= adc_dma_pkg::ENG_IDLE;
            cur_ff   <= `RST_BUF_START; // R5
            count_ff <= `RST_BUF_LENGTH;
        end else if (eng_rst_req) begin
            state_ff <= adc_dma_pkg::ENG_IDLE; // R16
            cur_ff   <= start_ff;
            count_ff <= 13'h0000;
        end else if (load_req) begin
            state_ff <= adc_dma_pkg::ENG_LOAD; // R14
        end else begin
            unique case (state_ff)
                adc_dma_pkg::ENG_IDLE: begin
                    state_ff <= adc_dma_pkg::ENG_IDLE;
                end
                adc_dma_pkg::ENG_LOAD: begin
                    state_ff <= adc_dma_pkg::ENG_RUN; // R14
                    cur_ff   <= start_ff;
                    count_ff <= 13'h0000;
                end
                adc_dma_pkg::ENG_RUN: begin
                    if (hit_full && wrap_ff) begin
                        cur_ff   <= start_ff; // R15
                        count_ff <= 13'h0000;
                    end else if (hit_full) begin
                        state_ff <= adc_dma_pkg::ENG_IDLE; // R15
                        cur_ff   <= cur_ff + `ADDR_STEP;
                        count_ff <= nxt_count;
                    end else if (store) begin
                        cur_ff   <= cur_ff + `ADDR_STEP; // R20
                        count_ff <= nxt_count;
                    end
                end
                default: begin
                    state_ff <= adc_dma_pkg::ENG_IDLE;
                end
            endcase
        end
    end

    // The RAM port is registered so the write lands one cycle after the result
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ram_we_ff   <= 1'b0;
            ram_addr_ff <= `RAM_BASE_ADDR;
            ram_data_ff <= 16'h0000;
        end else begin
            ram_we_ff <= store; // R20
            if (store) begin
                ram_addr_ff <= `RAM_BASE_ADDR | {18'h00000, cur_ff};
                ram_data_ff <= ADC_RESULT;
            end
        end
    end

    assign RAM_WR_EN   = ram_we_ff;
    assign RAM_WR_ADDR = ram_addr_ff;
    assign RAM_WR_DATA = ram_data_ff;

    // Overflow status is only cleared by engine reset; a new overflow wins
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ovf_status_ff <= 1'b0;
        end else if (overflow_ev) begin
            ovf_status_ff <= 1'b1; // R17
        end else if (eng_rst_req) begin
            ovf_status_ff <= 1'b0; // R16
        end
    end

    // Pending flags: write one to clear, a same-cycle event keeps the flag set
    always_comb begin
        irq_set                       = 5'h00;
        irq_set[`BIT_OVERFLOW_IRQ]    = overflow_ev; // R6
        irq_set[`BIT_SATURATION_IRQ]  = ADC_GAIN_SAT; // R7
        irq_set[`BIT_BUFFER_FULL_IRQ] = hit_full; // R8
        irq_set[`BIT_BUFFER_HALF_IRQ] = hit_half; // R9
        irq_set[`BIT_RESULT_READY]    = ADC_RESULT_VALID; // R10
    end

    assign irq_clr     = (do_write && aw_addr_ff == `OFS_IRQ_PENDING) ? wr_word[4:0] : 5'h00;
    assign nxt_pending = (pending_ff & ~irq_clr) | irq_set; // R19

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pending_ff <= `RST_IRQ_PENDING;
        end else begin
            pending_ff <= nxt_pending;
        end
    end

    // Request follows the flags one cycle later so it comes from a flip-flop
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(pending_ff & enable_ff); // R12 R19
        end
    end

    assign IRQ_ADC = irq_ff;

endmodule

// ### tb/adc_result_dma_checker.sv
// Port-level assertions for the ADC result transfer engine
`timescale 1ns/100ps
module adc_result_dma_checker (
    // Clock and reset
    input wire logic        CLK,
    input wire logic        RST,
    // Register bus
    input wire logic        AWREADY,
    input wire logic        WREADY,
    input wire logic [1:0]  BRESP,
    input wire logic        BVALID,
    input wire logic        BREADY,
    input wire logic        ARVALID,
    input wire logic        ARREADY,
    input wire logic [31:0] RDATA,
    input wire logic        RVALID,
    input wire logic        RREADY,
    // Conversion core and RAM port
    input wire logic        ADC_RESULT_VALID,
    input wire logic [15:0] ADC_RESULT,
    input wire logic        RAM_WR_EN,
    input wire logic [31:0] RAM_WR_ADDR,
    input wire logic [15:0] RAM_WR_DATA
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    store_cause_a: assert property (RAM_WR_EN |-> $past(ADC_RESULT_VALID))
        else $error("store without a result");
    store_data_a: assert property (RAM_WR_EN |-> RAM_WR_DATA == $past(ADC_RESULT))
        else $error("stored data differs from result");
    store_addr_a: assert property (RAM_WR_EN |->
        RAM_WR_ADDR[31:14] == 18'h08000 && !RAM_WR_ADDR[0])
        else $error("store address outside RAM or odd");
    resp_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response dropped early");
    data_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read data dropped early");
    write_busy_a: assert property (BVALID |-> !AWREADY && !WREADY)
        else $error("write accepted during response");
    read_busy_a: assert property (RVALID |-> !ARREADY)
        else $error("read accepted during response");
    read_answer_a: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("read answer late");
endmodule

bind adc_result_dma adc_result_dma_checker adc_result_dma_checker_i (
    .CLK(CLK), .RST(RST), .AWREADY(AWREADY), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY), .ADC_RESULT(ADC_RESULT),
    .ADC_RESULT_VALID(ADC_RESULT_VALID), .RAM_WR_EN(RAM_WR_EN),
    .RAM_WR_ADDR(RAM_WR_ADDR), .RAM_WR_DATA(RAM_WR_DATA));

// ### tb/adc_core_model.sv
// Behavioural conversion core and RAM write port facing the transfer engine
`timescale 1ns/100ps
module adc_core_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Conversion results
    output logic             result_valid,
    output logic [15:0]      result,
    output logic             gain_sat,
    // RAM write port
    input  wire logic        ram_wr_en,
    input  wire logic [31:0] ram_wr_addr,
    input  wire logic [15:0] ram_wr_data
);
    logic [15:0] mem [0:8191];
    logic [15:0] seq = 16'hA000;

    initial begin
        result_valid = 1'h0;
        result = 16'hFFFF;
        gain_sat = 1'h0;
    end
    // Indexed by halfword; the base bits are left to the checker
    always @(posedge clk) begin
        if (!rst && ram_wr_en) begin
            mem[ram_wr_addr[13:1]] <= ram_wr_data;
        end
    end
    // A gap of 0 gives back-to-back results; idle data never repeats a stale value
    task automatic send(input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            result_valid <= 1'h1;
            result <= seq;
            seq = seq + 16'h0001;
            repeat (gap) begin
                @(posedge clk);
                result_valid <= 1'h0;
                result <= ~seq;
            end
        end
        @(posedge clk);
        result_valid <= 1'h0;
        result <= ~seq;
    endtask
    task automatic saturate();
        @(posedge clk);
        gain_sat <= 1'h1;
        @(posedge clk);
        gain_sat <= 1'h0;
    endtask
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the ADC result transfer engine
`timescale 1ns/100ps
`include "adc_dma_regs.svh"
module tb_top;
    logic        CLK = 1'h0, RST = 1'h1;
    logic [31:0] AWADDR = 32'h0, WDATA = 32'h0, ARADDR = 32'h0, RDATA, RAM_WR_ADDR, rd;
    logic [3:0]  WSTRB = 4'hF, strb = 4'hF;
    logic        AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0, ARVALID = 1'h0;
    logic        RREADY = 1'h0, AWREADY, WREADY, BVALID, ARREADY, RVALID;
    logic        ADC_RESULT_VALID, ADC_GAIN_SAT, RAM_WR_EN, IRQ_ADC;
    logic [1:0]  BRESP, RRESP, rsp;
    logic [15:0] ADC_RESULT, RAM_WR_DATA;
    int          num_errors = 0, compares = 0, cycles = 0;

    adc_result_dma adc_result_dma_i (
        .CLK(CLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
        .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
        .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
        .ADC_RESULT_VALID(ADC_RESULT_VALID), .ADC_RESULT(ADC_RESULT),
        .ADC_GAIN_SAT(ADC_GAIN_SAT), .RAM_WR_EN(RAM_WR_EN), .RAM_WR_ADDR(RAM_WR_ADDR),
        .RAM_WR_DATA(RAM_WR_DATA), .IRQ_ADC(IRQ_ADC));
    adc_core_model adc_core_model_i (
        .clk(CLK), .rst(RST), .result_valid(ADC_RESULT_VALID), .result(ADC_RESULT),
        .gain_sat(ADC_GAIN_SAT), .ram_wr_en(RAM_WR_EN), .ram_wr_addr(RAM_WR_ADDR),
        .ram_wr_data(RAM_WR_DATA));

    always #2 CLK = ~CLK;
    // The run needs well under a thousand bus cycles
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            results();
        end
    end

    task automatic results();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One transfer; each channel is released at the edge that takes it, the answer likewise
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        logic b;
        b = 1'h0;
        @(posedge CLK);
        AWADDR <= a;
        ARADDR <= a;
        WDATA <= d;
        WSTRB <= strb;
        AWVALID <= w;
        WVALID <= w;
        ARVALID <= !w;
        BREADY <= w;
        RREADY <= !w;
        while (!b) begin
            @(posedge CLK);
            if (AWVALID && AWREADY) AWVALID <= 1'h0;
            if (WVALID && WREADY) WVALID <= 1'h0;
            if (ARVALID && ARREADY) ARVALID <= 1'h0;
            b = w ? BVALID : RVALID;
            rsp = w ? BRESP : RRESP;
            rd = RDATA;
        end
        BREADY <= 1'h0;
        RREADY <= 1'h0;
    endtask

    task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
        bus(1'h0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic t_regs();
        rchk(`OFS_BUF_START, 32'h20000000);
        rchk(`OFS_NEXT_WRITE, 32'h20000000);
        rchk(`OFS_BUF_LENGTH, 32'h0);
        rchk(`OFS_STORED_COUNT, 32'h0);
        rchk(`OFS_IRQ_PENDING, 32'h0);
        bus(1'h1, `OFS_BUF_START, 32'hFFFFFFFF);
        rchk(`OFS_BUF_START, 32'h20003FFE);
        strb = 4'h1;
        bus(1'h1, `OFS_BUF_LENGTH, 32'hFFFFFFFF);
        strb = 4'hF;
        rchk(`OFS_BUF_LENGTH, 32'h000000FF);
        bus(1'h1, `OFS_BUF_LENGTH, 32'hFFFFFFFF);
        rchk(`OFS_BUF_LENGTH, 32'h00001FFF);
        bus(1'h1, `OFS_NEXT_WRITE, 32'h0);
        rchk(`OFS_NEXT_WRITE, 32'h20000000);
        bus(1'h1, 32'h4000D028, 32'h1);
        chk({30'h0, rsp}, {30'h0, `RESP_SLVERR});
        rchk(32'h4000D028, 32'h0);
        chk({30'h0, rsp}, {30'h0, `RESP_SLVERR});
    endtask

    task automatic t_linear();
        bus(1'h1, `OFS_BUF_START, 32'h00000100);
        bus(1'h1, `OFS_BUF_LENGTH, 32'h4);
        bus(1'h1, `OFS_IRQ_ENABLE, 32'h1F);
        bus(1'h1, `OFS_XFER_CONTROL, 32'h1);
        rchk(`OFS_XFER_CONTROL, 32'h0);
        adc_core_model_i.send(4, 0);
        repeat (3) @(posedge CLK);
        chk({31'h0, IRQ_ADC}, 32'h1);
        rchk(`OFS_IRQ_PENDING, 32'h07);
        rchk(`OFS_STORED_COUNT, 32'h4);
        rchk(`OFS_NEXT_WRITE, 32'h20000108);
        rchk(`OFS_XFER_STATUS, 32'h0);
        for (int i = 0; i < 4; i++) begin
            chk({16'h0, adc_core_model_i.mem[13'h0080 + i]}, 32'hA000 + i);
        end
        adc_core_model_i.send(1, 2);
        rchk(`OFS_IRQ_PENDING, 32'h17);
        rchk(`OFS_XFER_STATUS, 32'h2);
        rchk(`OFS_STORED_COUNT, 32'h4);
    endtask

    task automatic t_irq();
        bus(1'h1, `OFS_IRQ_PENDING, 32'h1F);
        rchk(`OFS_IRQ_PENDING, 32'h0);
        chk({31'h0, IRQ_ADC}, 32'h0);
        bus(1'h1, `OFS_IRQ_ENABLE, 32'h08);
        adc_core_model_i.saturate();
        repeat (3) @(posedge CLK);
        chk({31'h0, IRQ_ADC}, 32'h1);
        bus(1'h1, `OFS_IRQ_ENABLE, 32'h0);
        repeat (2) @(posedge CLK);
        chk({31'h0, IRQ_ADC}, 32'h0);
        rchk(`OFS_IRQ_PENDING, 32'h08);
    endtask

    task automatic t_wrap();
        bus(1'h1, `OFS_IRQ_PENDING, 32'h1F);
        bus(1'h1, `OFS_BUF_LENGTH, 32'h2);
        bus(1'h1, `OFS_XFER_CONTROL, 32'h3);
        rchk(`OFS_XFER_CONTROL, 32'h2);
        adc_core_model_i.send(3, 1);
        rchk(`OFS_STORED_COUNT, 32'h1);
        rchk(`OFS_NEXT_WRITE, 32'h20000102);
        rchk(`OFS_XFER_STATUS, 32'h3);
        chk({16'h0, adc_core_model_i.mem[13'h0080]}, 32'hA007);
        rchk(`OFS_IRQ_PENDING, 32'h07);
        bus(1'h1, `OFS_XFER_CONTROL, 32'h10);
        rchk(`OFS_XFER_STATUS, 32'h0);
        rchk(`OFS_XFER_CONTROL, 32'h0);
        rchk(`OFS_NEXT_WRITE, 32'h20000100);
        rchk(`OFS_STORED_COUNT, 32'h0);
    endtask

    initial begin
        repeat (20) @(posedge CLK);
        RST <= 1'h0;
        t_regs();
        t_linear();
        t_irq();
        t_wrap();
        results();
    end
endmodule
